// >>> common/guard_pkg.sv
package guard_pkg;
    // sample and tracking widths
    localparam int unsigned SAMPLE_W      = 12;
    localparam int unsigned CHANNELS      = 2;
    // fault hold: more than one millisecond
    localparam int unsigned FAULT_HOLD_US = 1100;
    localparam int unsigned CLK_MHZ       = 125;
    localparam int unsigned FAULT_CYCLES  = FAULT_HOLD_US * CLK_MHZ;
    // defaults for undocumented values
    localparam int unsigned WDOG_CYCLES   = 250000;
    localparam logic [11:0] AMP_MIN       = 12'h040;
    localparam logic [11:0] STEP_MAX      = 12'h010;
    localparam logic [11:0] PEAK_RST_HI   = 12'h000;
    localparam logic [11:0] PEAK_RST_LO   = 12'h000;
    localparam int unsigned PULSE_CYCLES  = 64;

    typedef enum logic [3:0] {
        PROTO_SPEED      = 4'h1,
        PROTO_SPEED_DIR  = 4'h2,
        PROTO_PULSE      = 4'h4,
        PROTO_PULSE_DIR  = 4'h8
    } proto_e;

    typedef enum logic [2:0] {
        ST_RUN   = 3'h1,
        ST_FAULT = 3'h2,
        ST_RESET = 3'h4
    } fault_state_e;

    typedef struct packed {
        logic signed [11:0] hi;
        logic signed [11:0] lo;
    } peaks_s;
endpackage

// >>> design/speed_sensor_tracking_guard.sv
// What this block does
// - freeze output when amplitude below minimum
// - release frozen output when amplitude recovers
// - per channel lockout for non-direction protocols
// - joint lockout when protocol carries direction
// - no peak contraction after direction reversal
// - peak updates limited to bounded step, except recalibration widens straight to the sample
// - temperature gain correction before peak tracking
// - stopped watchdog shifts both peaks together
// - any diagnostic drives outputs to fault
// - hold fault long enough to observe
// - clearable faults reset controller after hold
// - large amplitude mismatch triggers immediate recalibration
// - no transitions while a pulse runs
// - collision guard only for pulse protocols
// - fault drives both outputs high fault
// - fault held longer than one millisecond
`timescale 1ns/100ps
module speed_sensor_tracking_guard #(
    parameter int unsigned       FAULT_CYCLES = guard_pkg::FAULT_CYCLES,
    parameter int unsigned       WDOG_CYCLES  = guard_pkg::WDOG_CYCLES,
    parameter logic [11:0]       AMP_MIN      = guard_pkg::AMP_MIN,
    parameter logic [11:0]       STEP_MAX     = guard_pkg::STEP_MAX,
    parameter int unsigned       PULSE_CYCLES = guard_pkg::PULSE_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   sample_valid,
    input  wire logic signed [11:0]     sample_a,
    input  wire logic signed [11:0]     sample_b,
    input  wire logic [7:0]             temp_gain,
    input  wire guard_pkg::proto_e      proto_sel,
    input  wire logic                   diag_fault,
    input  wire logic                   diag_clearable,
    output logic                        first_output,
    output logic                        second_output,
    output logic                        fault_high,
    output logic                        ctrl_reset,
    output logic [1:0]                  lockout,
    output logic [1:0]                  recal
);
    localparam int FW = $clog2(FAULT_CYCLES + 1);
    localparam int WW = $clog2(WDOG_CYCLES + 1);
    localparam int PW = $clog2(PULSE_CYCLES + 1);
    default clocking dck @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------
    // fault sequencing
    // ----------------------------------------------------------
    guard_pkg::fault_state_e fstate_ff;
    logic [FW-1:0]           fcnt_ff;
    logic                    fclear_ff;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fstate_ff <= guard_pkg::ST_RUN;
            fcnt_ff   <= '0;
            fclear_ff <= 1'b0;
        end
        else
        begin
            unique case (fstate_ff)
                guard_pkg::ST_RUN:
                begin
                    fcnt_ff <= '0;
                    if (diag_fault)
                    begin
                        fstate_ff <= guard_pkg::ST_FAULT;
                        fclear_ff <= diag_clearable;
                    end
                end
                guard_pkg::ST_FAULT:
                begin
                    // a non-clearable fault keeps the outputs at fault for good
                    if (fcnt_ff < FW'(FAULT_CYCLES))
                        fcnt_ff <= fcnt_ff + 1'b1;
                    else if (fclear_ff)
                        fstate_ff <= guard_pkg::ST_RESET;
                end
                guard_pkg::ST_RESET:
                begin
                    fstate_ff <= guard_pkg::ST_RUN;
                    fclear_ff <= 1'b0;
                end
            endcase
        end
    end

    wire in_fault = (fstate_ff != guard_pkg::ST_RUN);
    wire soft_rst = (fstate_ff == guard_pkg::ST_RESET);

    // ----------------------------------------------------------
    // per channel tracking
    // ----------------------------------------------------------
    wire pulse_mode = proto_sel inside {guard_pkg::PROTO_PULSE, guard_pkg::PROTO_PULSE_DIR};
    wire dir_mode   = proto_sel inside {guard_pkg::PROTO_SPEED_DIR, guard_pkg::PROTO_PULSE_DIR};
    logic [1:0] small_sig;
    logic [1:0] sw_state;
    logic [1:0] rev_seen;
    logic [WW-1:0] wdog_ff;
    logic          stopped;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wdog_ff <= '0;
        else if (soft_rst || (|(sw_state ^ {second_output, first_output})))
            wdog_ff <= '0;
        else if (sample_valid && wdog_ff < WW'(WDOG_CYCLES))
            wdog_ff <= wdog_ff + 1'b1;
    end
    assign stopped = (wdog_ff == WW'(WDOG_CYCLES));
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_ch
            guard_pkg::peaks_s  pk_ff;
            logic signed [11:0] last_ff;
            logic               rise_ff;
            logic               sw_ff;
            logic signed [19:0] prod;
            logic signed [11:0] norm;
            logic signed [12:0] span;
            logic signed [11:0] mid;
            logic signed [11:0] raw;
            assign raw  = (ch == 0) ? sample_a : sample_b;
            assign prod = raw * $signed({1'b0, temp_gain});
            assign norm = prod[17:6];
            assign span = 13'(pk_ff.hi) - 13'(pk_ff.lo);
            assign mid  = 12'((13'(pk_ff.hi) + 13'(pk_ff.lo)) >>> 1);
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    pk_ff    <= '{hi: guard_pkg::PEAK_RST_HI, lo: guard_pkg::PEAK_RST_LO};
                    last_ff  <= '0;
                    rise_ff  <= 1'b1;
                    sw_ff    <= 1'b0;
                    rev_seen[ch] <= 1'b0;
                    recal[ch]    <= 1'b0;
                end
                else if (soft_rst)
                begin
                    pk_ff    <= '{hi: guard_pkg::PEAK_RST_HI, lo: guard_pkg::PEAK_RST_LO};
                    rev_seen[ch] <= 1'b0;
                    recal[ch]    <= 1'b0;
                end
                else if (sample_valid)
                begin
                    last_ff <= norm;
                    recal[ch] <= 1'b0;
                    if ((norm > last_ff) != rise_ff && norm != last_ff)
                    begin
                        rise_ff <= (norm > last_ff);
                        rev_seen[ch] <= 1'b1;
                    end
                    if (13'(norm) - 13'(pk_ff.lo) > (span <<< 1) ||
                        13'(pk_ff.hi) - 13'(norm) > (span <<< 1))
                    begin
                        // widen to the sample; collapsing both peaks would leave no span
                        pk_ff.hi  <= (norm > pk_ff.hi) ? norm : pk_ff.hi;
                        pk_ff.lo  <= (norm < pk_ff.lo) ? norm : pk_ff.lo;
                        recal[ch] <= 1'b1;
                    end
                    else if (stopped)
                    begin
                        // move both peaks by the same offset to keep the span
                        if (norm > mid)
                            pk_ff <= '{hi: pk_ff.hi + 12'sh001, lo: pk_ff.lo + 12'sh001};
                        else if (norm < mid)
                            pk_ff <= '{hi: pk_ff.hi - 12'sh001, lo: pk_ff.lo - 12'sh001};
                    end
                    else
                    begin
                        if (norm > pk_ff.hi)
                            pk_ff.hi <= (norm - pk_ff.hi > $signed(STEP_MAX)) ?
                                pk_ff.hi + $signed(STEP_MAX) : norm;
                        else if (!rev_seen[ch] && norm < pk_ff.hi)
                            pk_ff.hi <= pk_ff.hi - 12'sh001;
                        if (norm < pk_ff.lo)
                            pk_ff.lo <= (pk_ff.lo - norm > $signed(STEP_MAX)) ?
                                pk_ff.lo - $signed(STEP_MAX) : norm;
                        else if (!rev_seen[ch] && norm > pk_ff.lo)
                            pk_ff.lo <= pk_ff.lo + 12'sh001;
                    end
                    if (norm > mid + 12'(span >>> 2))
                        sw_ff <= 1'b1;
                    else if (norm < mid - 12'(span >>> 2))
                        sw_ff <= 1'b0;
                end
            end
            assign small_sig[ch] = span < $signed({1'b0, AMP_MIN});
            assign sw_state[ch]  = sw_ff;
        end
    endgenerate

    // ----------------------------------------------------------
    // lockout, collision guard and output drive
    // ----------------------------------------------------------
    logic [1:0]    lock_now;
    logic [PW-1:0] pcnt_ff [2];
    assign lock_now = dir_mode ? {2{|small_sig}} : small_sig;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lockout <= 2'h0;
        else
            lockout <= lock_now;
    end
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_out
            logic out_ff;
            wire  busy = pulse_mode && (pcnt_ff[ch] != '0);
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    out_ff      <= 1'b0;
                    pcnt_ff[ch] <= '0;
                end
                else
                begin
                    if (pcnt_ff[ch] != '0)
                        pcnt_ff[ch] <= pcnt_ff[ch] - 1'b1;
                    // frozen while locked, released once amplitude is back
                    if (!lock_now[ch] && !busy && sw_state[ch] != out_ff)
                    begin
                        out_ff <= sw_state[ch];
                        if (pulse_mode)
                            pcnt_ff[ch] <= PW'(PULSE_CYCLES);
                    end
                end
            end
        end
    endgenerate
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            first_output  <= 1'b0;
            second_output <= 1'b0;
            fault_high    <= 1'b0;
            ctrl_reset    <= 1'b0;
        end
        else
        begin
            first_output  <= in_fault ? 1'b1 : g_out[0].out_ff;
            second_output <= in_fault ? 1'b1 : g_out[1].out_ff;
            fault_high    <= (fstate_ff == guard_pkg::ST_FAULT);
            ctrl_reset    <= soft_rst;
        end
    end

    // ----------------------------------------------------------
    // assertions
    // ----------------------------------------------------------
    property p_fault_entry;
        (fstate_ff == guard_pkg::ST_RUN && diag_fault) |=> ##1 (fault_high && first_output);
    endproperty
    a_fault_entry: assert property (p_fault_entry) else $error("fault not driven");
    property p_both_high;
        fault_high |-> (first_output && second_output);
    endproperty
    a_both_high: assert property (p_both_high) else $error("fault not on both");
    property p_hold;
        (fstate_ff == guard_pkg::ST_FAULT && fcnt_ff < FW'(FAULT_CYCLES)) |=> in_fault;
    endproperty
    a_hold: assert property (p_hold) else $error("fault left early");
    property p_clear;
        soft_rst |-> ($past(fclear_ff) && $past(fcnt_ff) == FW'(FAULT_CYCLES));
    endproperty
    a_clear: assert property (p_clear) else $error("reset without hold");
    property p_freeze;
        lock_now[0] |=> $stable(g_out[0].out_ff);
    endproperty
    a_freeze: assert property (p_freeze) else $error("locked output moved");
    property p_joint;
        (dir_mode && |small_sig) |=>
            (&lockout && $stable(g_out[0].out_ff) && $stable(g_out[1].out_ff));
    endproperty
    a_joint: assert property (p_joint) else $error("joint lockout missing");
    property p_collision;
        (pulse_mode && pcnt_ff[1] != '0) |=> $stable(g_out[1].out_ff);
    endproperty
    a_collision: assert property (p_collision) else $error("pulse cut");
    property p_release;
        (!lock_now[0] && !pulse_mode && sw_state[0] != g_out[0].out_ff)
            |=> g_out[0].out_ff == $past(sw_state[0]);
    endproperty
    a_release: assert property (p_release) else $error("output not released");
    c_fault:   cover property (soft_rst);
    c_lock:    cover property (lock_now == 2'h1);
    c_recal:   cover property (|recal);
    c_stopped: cover property (stopped);
endmodule

// >>> bench/controller_model.sv
`timescale 1ns/100ps
// --------------------------------------------------------------
// system controller watching the two sensor outputs
// --------------------------------------------------------------
module controller_model #(
    parameter int unsigned HOLD = 20
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic first_output,
    input  wire logic second_output,
    input  wire logic fault_high,
    output logic      fault_seen
);
    int unsigned run_ff;

    // short excursions are normal transitions, only a long hold is a fault
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_ff     <= 0;
            fault_seen <= 1'b0;
        end
        else if (fault_high && first_output && second_output)
        begin
            run_ff <= run_ff + 1;
            if (run_ff >= HOLD)
                fault_seen <= 1'b1;
        end
        else
            run_ff <= 0;
    end
endmodule

// >>> bench/speed_sensor_tracking_guard_tb.sv
`timescale 1ns/100ps
module speed_sensor_tracking_guard_tb;
    localparam int unsigned FAULT_N = 20;
    localparam int unsigned PULSE_N = 8;
    logic               clk;
    logic               rst_n;
    logic               sample_valid;
    logic signed [11:0] sample_a;
    logic signed [11:0] sample_b;
    logic [7:0]         temp_gain;
    guard_pkg::proto_e  proto_sel;
    logic               diag_fault;
    logic               diag_clearable;
    logic               first_output;
    logic               second_output;
    logic               fault_high;
    logic               ctrl_reset;
    logic [1:0]         lockout;
    logic [1:0]         recal;
    logic               fault_seen;
    int                 bad_count;
    int                 checked;
    int                 cycles;
    int                 any_recal;
    int                 b_moves;
    int                 min_gap;

    speed_sensor_tracking_guard #(.FAULT_CYCLES(FAULT_N), .WDOG_CYCLES(50),
        .PULSE_CYCLES(PULSE_N)) speed_sensor_tracking_guard_i (
        .clk(clk), .rst_n(rst_n), .sample_valid(sample_valid),
        .sample_a(sample_a), .sample_b(sample_b), .temp_gain(temp_gain),
        .proto_sel(proto_sel), .diag_fault(diag_fault),
        .diag_clearable(diag_clearable), .first_output(first_output),
        .second_output(second_output), .fault_high(fault_high),
        .ctrl_reset(ctrl_reset), .lockout(lockout), .recal(recal));

    controller_model #(.HOLD(FAULT_N)) controller_model_i (
        .clk(clk), .rst_n(rst_n), .first_output(first_output),
        .second_output(second_output), .fault_high(fault_high),
        .fault_seen(fault_seen));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // a hang must still reach the verdict
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic do_reset(input guard_pkg::proto_e p);
        rst_n     = 1'b0;
        proto_sel = p;
        step(12);
        rst_n = 1'b1;
        step(1);
    endtask

    // square wave, four samples per half period; tracks toggle spacing
    task automatic feed(input int n, input logic signed [11:0] amp_a, amp_b);
        logic prev_a;
        logic prev_b;
        int   gap;
        prev_a    = first_output;
        prev_b    = second_output;
        // the first change after reset is no pulse spacing, so it must not count
        gap       = 1000;
        any_recal = 0;
        b_moves   = 0;
        min_gap   = 1000;
        for (int i = 0; i < n; i++)
        begin
            sample_valid = 1'b1;
            sample_a = i[2] ? -amp_a : amp_a;
            sample_b = i[2] ? -amp_b : amp_b;
            step(1);
            gap++;
            if (recal !== 2'h0)
                any_recal = 1;
            if (second_output !== prev_b)
                b_moves++;
            if (first_output !== prev_a)
            begin
                if (gap < min_gap)
                    min_gap = gap;
                gap = 0;
            end
            prev_a = first_output;
            prev_b = second_output;
        end
        sample_valid = 1'b0;
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_lock_joint();
        do_reset(guard_pkg::PROTO_SPEED_DIR);
        check("outputs_after_reset", {fault_high, ctrl_reset, first_output}, 12'h000);
        feed(64, 12'sh300, 12'sh000);
        check("joint_lockout", lockout, 12'h003);
        check("recal_seen", any_recal, 12'h001);
    endtask

    task automatic t_lock_chan();
        do_reset(guard_pkg::PROTO_SPEED);
        feed(64, 12'sh300, 12'sh000);
        check("lockout_b", lockout[1], 12'h001);
        check("frozen_b_moves", b_moves, 12'h000);
        check("a_gap_speed", min_gap, 12'h004);
    endtask

    task automatic t_pulse(input guard_pkg::proto_e p);
        do_reset(p);
        feed(128, 12'sh300, 12'sh300);
        check("pulse_lockout_clear", lockout, 12'h000);
        check("pulse_spacing_ok", min_gap >= PULSE_N && min_gap < 1000, 12'h001);
    endtask

    task automatic t_fault(input logic clearable);
        int n;
        do_reset(guard_pkg::PROTO_SPEED);
        diag_fault     = 1'b1;
        diag_clearable = clearable;
        step(1);
        diag_fault = 1'b0;
        step(2);
        check("fault_levels", {fault_high, first_output, second_output}, 12'h007);
        n = 2;
        while (fault_high === 1'b1 && n < 200)
        begin
            n++;
            step(1);
        end
        if (clearable)
        begin
            check("hold_long_enough", n >= FAULT_N + 1, 12'h001);
            check("ctrl_reset_pulse", {fault_high, ctrl_reset}, 12'h001);
            check("controller_saw_fault", fault_seen, 12'h001);
            step(1);
            check("ctrl_reset_one_cycle", ctrl_reset, 12'h000);
        end
        else
        begin
            check("nonclearable_stays", {fault_high, second_output}, 12'h003);
            check("controller_saw_hold", fault_seen, 12'h001);
        end
    endtask

    initial
    begin
        rst_n          = 1'b0;
        sample_valid   = 1'b0;
        sample_a       = 12'sh000;
        sample_b       = 12'sh000;
        temp_gain      = 8'h40;
        proto_sel      = guard_pkg::PROTO_SPEED;
        diag_fault     = 1'b0;
        diag_clearable = 1'b0;
        bad_count      = 0;
        checked        = 0;
        cycles         = 0;
        step(1);
        t_lock_joint();
        t_lock_chan();
        t_pulse(guard_pkg::PROTO_PULSE);
        t_pulse(guard_pkg::PROTO_PULSE_DIR);
        t_fault(1'b1);
        t_fault(1'b0);
        end_of_test();
    end
endmodule
